// *** src/lss_pkg.sv ***
/*
 types of the load shed sequencer: sequencing states and the status word.
 assumes nothing of its surroundings.
*/
package lss_pkg;
	typedef enum logic [2:0] {
		ST_ALLON = 3'b001,
		ST_SHED = 3'b010,
		ST_STEP = 3'b100
	} lss_state_t;

	typedef struct packed {
		logic [13:0] rsvd;
		logic freq_ovl;
		logic on_gen;
		logic newer;
		lss_state_t state;
		logic [3:0] tmp_blk;
		logic [3:0] perm_blk;
		logic [3:0] load_en;
	} lss_status_t;
endpackage

// *** src/lss_regs.svh ***
/*
 register offsets, field positions, reset values and timing counts of the load shed sequencer.
 assumes a 10 MHz system clock and an APB slave with 8-bit byte addresses.
*/
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH
`define LSS_CLK_HZ 10000000
`define LSS_TICK_MS 100
`define LSS_TICK_CYC (`LSS_CLK_HZ / 1000 * `LSS_TICK_MS)
`define LSS_LOW58_MS 3000
`define LSS_LOW50_MS 500
`define LSS_SHED_MIN 5
`define LSS_STEP_BASIC_S 30
`define LSS_STEP_NEW_S 15
`define LSS_HOLD_MIN 30
`define LSS_LOW58_TK (`LSS_LOW58_MS / `LSS_TICK_MS)
`define LSS_LOW50_TK (`LSS_LOW50_MS / `LSS_TICK_MS)
`define LSS_SHED_TK (`LSS_SHED_MIN * 60000 / `LSS_TICK_MS)
`define LSS_STEP_BASIC_TK (`LSS_STEP_BASIC_S * 1000 / `LSS_TICK_MS)
`define LSS_STEP_NEW_TK (`LSS_STEP_NEW_S * 1000 / `LSS_TICK_MS)
`define LSS_HOLD_TK (`LSS_HOLD_MIN * 60000 / `LSS_TICK_MS)
`define LSS_MAX_TRIES 3
`define LSS_BOOT_CYC 3'h5
`define LSS_REG_CTRL 8'h00
`define LSS_REG_STATUS 8'h04
`define LSS_REG_TRIES 8'h08
`define LSS_CTRL_TEST_BIT 0
`define LSS_CTRL_RST 1'b0
`define LSS_PIN_RST 5'h10
`define LSS_PIN_XFER 4
`define LSS_PIN_VAR 3
`define LSS_PIN_TEST 2
`define LSS_PIN_LO50 1
`define LSS_PIN_LO58 0
`endif

// *** src/lss_sequencer.sv ***
/*
 load shed sequencer: four priority load enables, under-frequency detection, staged recovery, APB registers.
 assumes pins are asynchronous to clock, the strap is static, and the APB master holds its request until pready.
*/
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "lss_regs.svh"

module lss_sequencer
	import lss_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `LSS_TICK_CYC,
	parameter int unsigned TW = 16,
	parameter logic [TW-1:0] T_LOW58 = TW'(`LSS_LOW58_TK),
	parameter logic [TW-1:0] T_LOW50 = TW'(`LSS_LOW50_TK),
	parameter logic [TW-1:0] T_SHED = TW'(`LSS_SHED_TK),
	parameter logic [TW-1:0] T_STEP_BASIC = TW'(`LSS_STEP_BASIC_TK),
	parameter logic [TW-1:0] T_STEP_NEW = TW'(`LSS_STEP_NEW_TK),
	parameter logic [TW-1:0] T_HOLD = TW'(`LSS_HOLD_TK)
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins from the switch, the frequency detector, the test button and the strap
	input wire logic transfer_n,
	input wire logic freq_below_58,
	input wire logic freq_below_50,
	input wire logic test_btn,
	input wire logic variant_sel,
	// load enables and lamps
	output logic [3:0] load_en,
	output logic [3:0] led
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers, a change counts once stages two and three agree

logic [4:0] s1_reg, s2_reg, s3_reg, filt_reg;
wire [4:0] pin_raw = {transfer_n, variant_sel, test_btn, freq_below_50, freq_below_58};
wire [4:0] filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		s1_reg <= `LSS_PIN_RST;
		s2_reg <= `LSS_PIN_RST;
		s3_reg <= `LSS_PIN_RST;
		filt_reg <= `LSS_PIN_RST;
	end else begin
		s1_reg <= pin_raw;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		filt_reg <= filt_next;
	end
end

wire on_gen = !filt_reg[`LSS_PIN_XFER];
wire f58 = filt_reg[`LSS_PIN_LO58];
wire f50 = filt_reg[`LSS_PIN_LO50];

////////////////////////////////////////////////////////////////////////////////
// strap capture after the synchroniser has settled

logic [2:0] boot_cnt_reg;
logic newer_reg;
wire boot_done = boot_cnt_reg == `LSS_BOOT_CYC;
wire boot_grab = boot_cnt_reg == (`LSS_BOOT_CYC - 3'h1);

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		boot_cnt_reg <= 3'h0;
		newer_reg <= 1'b0;
	end else begin
		boot_cnt_reg <= boot_done ? boot_cnt_reg : boot_cnt_reg + 3'h1;
		if (boot_grab) newer_reg <= filt_reg[`LSS_PIN_VAR];
	end
end

////////////////////////////////////////////////////////////////////////////////
// time base and under-frequency timers

logic [23:0] tick_cnt_reg;
logic [TW-1:0] c58_reg, c50_reg;
wire tick = tick_cnt_reg == 24'(TICK_CYCLES - 1);
wire hit58 = c58_reg == T_LOW58;
wire hit50 = c50_reg == T_LOW50;
wire freq_ovl = on_gen && (hit58 || hit50);
wire [TW-1:0] c58_next = !f58 ? '0 : (tick && !hit58) ? c58_reg + TW'(1) : c58_reg;
wire [TW-1:0] c50_next = !f50 ? '0 : (tick && !hit50) ? c50_reg + TW'(1) : c50_reg;

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		tick_cnt_reg <= 24'h0;
		c58_reg <= '0;
		c50_reg <= '0;
	end else begin
		tick_cnt_reg <= tick ? 24'h0 : tick_cnt_reg + 24'h1;
		c58_reg <= c58_next;
		c50_reg <= c50_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// overload and utility-return events

logic ctrl_test_reg, ovl_q_reg, on_gen_q_reg;
wire ovl_lvl = freq_ovl || filt_reg[`LSS_PIN_TEST] || ctrl_test_reg;
wire ovl_evt = ovl_lvl && !ovl_q_reg && boot_done;
wire util_evt = on_gen_q_reg && !on_gen;

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		ovl_q_reg <= 1'b0;
		on_gen_q_reg <= 1'b0;
	end else begin
		ovl_q_reg <= ovl_lvl;
		on_gen_q_reg <= on_gen;
	end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

lss_state_t st_reg, st_next;
logic [3:0] en_reg, en_next, perm_reg, perm_next, tmp_reg, tmp_next;
logic [3:0][1:0] tries_reg, tries_next;
logic [TW-1:0] seq_cnt_reg, seq_next, hold_cnt_reg, hold_next;
logic hold_run_reg, hold_run_next, last_vld_reg, last_vld_next;
logic [1:0] last_reg, last_next;

wire [3:0] blk = perm_reg | tmp_reg;
wire [3:0] free = ~en_reg & ~blk;
wire cand_vld = |free;
wire [1:0] cand_idx = free[0] ? 2'd0 : free[1] ? 2'd1 : free[2] ? 2'd2 : 2'd3;
wire [3:0] cand_oh = 4'h1 << cand_idx;
wire [TW-1:0] step_lim = newer_reg ? T_STEP_NEW : T_STEP_BASIC;
wire [TW-1:0] seq_lim = (st_reg == ST_SHED) ? T_SHED : step_lim;
wire seq_done = seq_cnt_reg == seq_lim;
wire win_open = (st_reg == ST_STEP) && last_vld_reg && !seq_done;
wire [3:0] last_oh = 4'h1 << last_reg;
wire [3:0] last_hi = ~(last_oh - 4'h1);
wire [3:0] fault_mask = newer_reg ? last_oh : last_hi;
wire fault = ovl_evt && win_open;
wire last_try = tries_reg[last_reg] == 2'(`LSS_MAX_TRIES - 1);
wire hold_done = hold_run_reg && (hold_cnt_reg == T_HOLD);

always_comb begin
	st_next = st_reg;
	en_next = en_reg;
	perm_next = perm_reg;
	tmp_next = tmp_reg;
	tries_next = tries_reg;
	last_next = last_reg;
	last_vld_next = last_vld_reg;
	seq_next = (tick && !seq_done) ? seq_cnt_reg + TW'(1) : seq_cnt_reg;
	hold_run_next = hold_run_reg;
	hold_next = (tick && hold_run_reg) ? hold_cnt_reg + TW'(1) : hold_cnt_reg;
	if (hold_done) begin
		tmp_next = 4'h0;
		hold_run_next = 1'b0;
	end
	unique case (st_reg)
		ST_ALLON: begin
			en_next = 4'hF;
			if (ovl_evt) begin
				st_next = ST_SHED;
				en_next = 4'h0;
				seq_next = '0;
			end
		end
		ST_SHED: begin
			if (ovl_evt) begin
				seq_next = '0;
			end else if (seq_done) begin
				st_next = ST_STEP;
				seq_next = '0;
				if (cand_vld) begin
					en_next = en_reg | cand_oh;
					last_next = cand_idx;
					last_vld_next = 1'b1;
				end
			end
		end
		ST_STEP: begin
			if (fault) begin
				tries_next[last_reg] = tries_reg[last_reg] + 2'h1;
				if (last_try) perm_next = perm_reg | fault_mask;
				else tmp_next = tmp_next | fault_mask;
				hold_next = '0;
				hold_run_next = 1'b1;
				seq_next = '0;
				last_vld_next = 1'b0;
				if (newer_reg) begin
					en_next = en_reg & ~last_oh;
				end else begin
					st_next = ST_SHED;
					en_next = 4'h0;
				end
			end else if (ovl_evt) begin
				st_next = ST_SHED;
				en_next = 4'h0;
				seq_next = '0;
				last_vld_next = 1'b0;
			end else if (seq_done && cand_vld) begin
				en_next = en_reg | cand_oh;
				last_next = cand_idx;
				last_vld_next = 1'b1;
				seq_next = '0;
			end
		end
	endcase
	if (util_evt) begin
		st_next = ST_ALLON;
		en_next = 4'hF;
		perm_next = 4'h0;
		tmp_next = 4'h0;
		tries_next = '0;
		hold_run_next = 1'b0;
		last_vld_next = 1'b0;
	end
end

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		st_reg <= ST_ALLON;
		en_reg <= 4'hF;
		perm_reg <= 4'h0;
		tmp_reg <= 4'h0;
		tries_reg <= '0;
		seq_cnt_reg <= '0;
		hold_cnt_reg <= '0;
		hold_run_reg <= 1'b0;
		last_reg <= 2'd0;
		last_vld_reg <= 1'b0;
	end else begin
		st_reg <= st_next;
		en_reg <= en_next;
		perm_reg <= perm_next;
		tmp_reg <= tmp_next;
		tries_reg <= tries_next;
		seq_cnt_reg <= seq_next;
		hold_cnt_reg <= hold_next;
		hold_run_reg <= hold_run_next;
		last_reg <= last_next;
		last_vld_reg <= last_vld_next;
	end
end

assign load_en = en_reg;
assign led = en_reg;

////////////////////////////////////////////////////////////////////////////////
// apb slave, read data captured in the setup cycle

lss_status_t status;
logic [31:0] prdata_reg;
logic pslverr_reg;
wire setup = psel && !penable;
wire acc_wr = psel && penable && pwrite;
wire sel_ctrl = paddr == `LSS_REG_CTRL;
wire sel_stat = paddr == `LSS_REG_STATUS;
wire sel_tries = paddr == `LSS_REG_TRIES;
wire mapped = sel_ctrl || sel_stat || sel_tries;
assign status = {14'h0, freq_ovl, on_gen, newer_reg, st_reg, tmp_reg, perm_reg, en_reg};
wire [31:0] rd_mux = sel_ctrl ? {31'h0, ctrl_test_reg} : sel_stat ? status : sel_tries ? {24'h0, tries_reg} : 32'h0;

always_ff @(posedge clock or negedge rst_b) begin
	if (!rst_b) begin
		prdata_reg <= 32'h0;
		pslverr_reg <= 1'b0;
		ctrl_test_reg <= `LSS_CTRL_RST;
	end else begin
		if (setup) prdata_reg <= rd_mux;
		if (setup) pslverr_reg <= !mapped;
		if (acc_wr && sel_ctrl) ctrl_test_reg <= pwdata[`LSS_CTRL_TEST_BIT];
	end
end

assign prdata = prdata_reg;
assign pready = psel && penable;
assign pslverr = pslverr_reg && pready;

////////////////////////////////////////////////////////////////////////////////
// assertions

default clocking cb @(posedge clock); endclocking
default disable iff (!rst_b);

sequence s_shed_end;
	st_reg == ST_SHED ##1 st_reg == ST_STEP;
endsequence

sequence s_step_rise;
	st_reg == ST_STEP && $past(st_reg) == ST_STEP && (en_reg & ~$past(en_reg)) != 4'h0;
endsequence

property p_util_allon;
	util_evt |=> en_reg == 4'hF && perm_reg == 4'h0 && st_reg == ST_ALLON;
endproperty
a_util_allon: assert property (p_util_allon) else $error("utility return did not restore loads");

property p_gen_hold;
	st_reg == ST_ALLON && !ovl_evt |=> en_reg == 4'hF;
endproperty
a_gen_hold: assert property (p_gen_hold) else $error("loads dropped without overload");

property p_shed_all;
	ovl_evt && !(fault && newer_reg) && !util_evt |=> en_reg == 4'h0 && st_reg == ST_SHED;
endproperty
a_shed_all: assert property (p_shed_all) else $error("overload did not shed all loads");

property p_freq;
	$rose(hit58 || hit50) |-> $past(c58_reg) == T_LOW58 - TW'(1) || $past(c50_reg) == T_LOW50 - TW'(1);
endproperty
a_freq: assert property (p_freq) else $error("overload declared at wrong duration");

property p_freq_clear;
	!f58 |=> c58_reg == '0;
endproperty
a_freq_clear: assert property (p_freq_clear) else $error("under-frequency timer not cleared");

property p_first_level;
	s_shed_end |-> $past(seq_cnt_reg) == T_SHED && (en_reg[0] || $past(blk[0]));
endproperty
a_first_level: assert property (p_first_level) else $error("first level not restored after shed");

property p_step;
	s_step_rise |-> $past(seq_cnt_reg) == $past(step_lim);
endproperty
a_step: assert property (p_step) else $error("level enabled off the step interval");

property p_bypass;
	fault && newer_reg && !util_evt |=> en_reg == ($past(en_reg) & ~$past(last_oh)) && st_reg == ST_STEP;
endproperty
a_bypass: assert property (p_bypass) else $error("newer fault did not drop only its level");

property p_basic_hold;
	fault && !newer_reg && !util_evt |=> (blk & $past(last_hi)) == $past(last_hi);
endproperty
a_basic_hold: assert property (p_basic_hold) else $error("basic fault did not block higher levels");

property p_lockout;
	fault && last_try && !util_evt |=> (perm_reg & $past(last_oh)) != 4'h0;
endproperty
a_lockout: assert property (p_lockout) else $error("third failure did not lock level");

property p_steady;
	st_reg == ST_STEP && en_reg == 4'hF && !ovl_evt |=> en_reg == 4'hF;
endproperty
a_steady: assert property (p_steady) else $error("steady levels dropped");

endmodule // lss_sequencer
`default_nettype wire

// *** test/lss_plant.sv ***
/*
 plant model: transfer switch and priority loads around the sequencer.
 assumes the bench changes gen, bad, deep and lo58 just after rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module lss_plant (
	// bench controls
	input wire logic gen,
	input wire logic [3:0] bad,
	input wire logic deep,
	input wire logic lo58,
	// sequencer side
	input wire logic [3:0] load_en,
	output logic transfer_n,
	output logic freq_below_58,
	output logic freq_below_50
);
	// a faulting level drags the frequency down while it is on and the plant runs on generator
	wire logic sag;
	assign sag = gen & |(load_en & bad);
	assign transfer_n = ~gen;
	assign freq_below_58 = sag | (gen & lo58);
	assign freq_below_50 = sag & deep;
endmodule // lss_plant
`default_nettype wire

// *** test/testbench.sv ***
/*
 self-checking bench of the load shed sequencer.
 assumes the plant model and shortened timing, one tick being four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
	import lss_pkg::*;
;
	localparam int TK = 4, L58 = 3, L50 = 2, SH = 6, SB = 8, SN = 4, HO = 20;
	logic clock, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic transfer_n, f58, f50, test_btn, variant_sel, gen, deep, lo58;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] load_en, led, bad;
	lss_status_t st;
	int failures, n_checks, seed, el, i;
	////////////////////////////////////////////////////////////////
	lss_sequencer #(.TICK_CYCLES(TK), .T_LOW58(16'(L58)), .T_LOW50(16'(L50)), .T_SHED(16'(SH)),
		.T_STEP_BASIC(16'(SB)), .T_STEP_NEW(16'(SN)), .T_HOLD(16'(HO))) i_dut (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .transfer_n(transfer_n),
		.freq_below_58(f58), .freq_below_50(f50), .test_btn(test_btn), .variant_sel(variant_sel),
		.load_en(load_en), .led(led));
	lss_plant i_plant (.gen(gen), .bad(bad), .deep(deep), .lo58(lo58), .load_en(load_en),
		.transfer_n(transfer_n), .freq_below_58(f58), .freq_below_50(f50));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 20);
		chk("pready", 32'(pready), 32'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) wrap_up();
	endtask
	// wait for the masked enables, el counts the cycles taken
	task automatic wt(input logic [3:0] m, input logic [3:0] v, input int b);
		el = 0;
		while ((load_en & m) !== v) begin
			@(posedge clock);
			el++;
			if (el > b) begin
				chk("load_en", 32'(load_en & m), 32'(v));
				wrap_up();
			end
		end
	endtask
	task automatic gap(input int lo, input int hi);
		chk("gap", 32'(el >= lo && el <= hi), 32'h1);
	endtask
	task automatic stay(input logic [3:0] v, input int n);
		bit ok;
		ok = 1'b1;
		repeat (n) begin
			@(posedge clock);
			if (load_en !== v || led !== v) ok = 1'b0;
		end
		chk("steady", 32'(ok), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 71110;
		failures = 0;
		n_checks = 0;
		{rst_b, psel, penable, pwrite, test_btn, variant_sel, gen, deep, lo58} = 9'h0;
		{paddr, pwdata, bad} = 44'h0;
		cyc(10);
		rst_b <= 1'b1;
		cyc(12);
		chk("load_en", 32'(load_en), 32'hF);
		chk("led", 32'(led), 32'hF);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", rd, 32'h0000100F);
		apb(1'b0, 8'h0C, 32'h0);
		chk("slverr", 32'(er), 32'h1);
		apb(1'b1, 8'h08, $random(seed));
		apb(1'b0, 8'h08, 32'h0);
		chk("tries", rd, 32'h0);
		// soft test on utility, then basic recovery
		apb(1'b1, 8'h00, 32'h1);
		wt(4'hF, 4'h0, 40);
		apb(1'b1, 8'h00, 32'h0);
		for (i = 1; i < 5; i++) begin
			wt(4'hF, 4'((1 << i) - 1), 100);
			if (i > 1) gap(SB * TK - TK, SB * TK + TK);
		end
		gen <= 1'b1;
		stay(4'hF, 60);
		for (i = 0; i < 6; i++) begin
			lo58 <= 1'b1;
			cyc(1 + ($random(seed) & 3));
			lo58 <= 1'b0;
			cyc(12);
		end
		chk("load_en", 32'(load_en), 32'hF);
		lo58 <= 1'b1;
		wt(4'hF, 4'h0, 40);
		gap(L58 * TK - TK, L58 * TK + TK + 6);
		lo58 <= 1'b0;
		bad <= 4'h4;
		deep <= 1'b1;
		wt(4'hF, 4'h1, 60);
		gap(SH * TK - TK, SH * TK + TK);
		wt(4'hF, 4'h3, 40);
		for (i = 0; i < 3; i++) begin
			wt(4'hF, 4'h7, 300);
			if (i > 0) gap(HO * TK - (SH + SB + 3) * TK, HO * TK - SH * TK);
			wt(4'hF, 4'h0, 40);
			wt(4'hF, 4'h3, 120);
		end
		stay(4'h3, 150);
		apb(1'b0, 8'h04, 32'h0);
		st = lss_status_t'(rd);
		chk("perm", 32'(st.perm_blk), 32'hC);
		gen <= 1'b0;
		bad <= 4'h0;
		wt(4'hF, 4'hF, 20);
		// newer variant, reset while on generator
		variant_sel <= 1'b1;
		gen <= 1'b1;
		rst_b <= 1'b0;
		cyc(10);
		rst_b <= 1'b1;
		stay(4'hF, 20);
		test_btn <= 1'b1;
		cyc(8);
		test_btn <= 1'b0;
		wt(4'hF, 4'h0, 30);
		wt(4'hF, 4'h1, 60);
		wt(4'hF, 4'h3, 40);
		gap(SN * TK - TK, SN * TK + TK);
		bad <= 4'h4;
		for (i = 0; i < 3; i++) begin
			wt(4'h4, 4'h4, 300);
			if (i > 0) gap(HO * TK - 2 * TK, HO * TK + SN * TK + TK);
			wt(4'h4, 4'h0, 20);
			chk("kept", 32'(load_en[1:0]), 32'h3);
		end
		wt(4'hF, 4'hB, 40);
		stay(4'hB, 120);
		apb(1'b0, 8'h04, 32'h0);
		st = lss_status_t'(rd);
		chk("perm", 32'(st.perm_blk), 32'h4);
		chk("newer", 32'(st.newer), 32'h1);
		gen <= 1'b0;
		bad <= 4'h0;
		wt(4'hF, 4'hF, 20);
		gen <= 1'b1;
		stay(4'hF, 40);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", rd, 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		wt(4'hF, 4'h0, 30);
		wt(4'hF, 4'hF, 120);
		stay(4'hF, 100);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
